// *** rtl/pse_cfg_pkg.sv ***
// Shared constants, types and decode helpers for the port configuration register bank
package pse_cfg_pkg;

  // ****************************************************************
  // Register offsets and field positions
  // ****************************************************************
  localparam logic [7:0] DISCONNECT_MONITOR_ENABLE_ADDR = 8'h13;
  localparam logic [7:0] DISCOVERY_CLASSIFY_ENABLE_ADDR = 8'h14;
  localparam logic [7:0] CADENCE_HIGHPOWER_ENABLE_ADDR  = 8'h15;
  localparam logic [7:0] PROTECTION_TIMING_ADDR         = 8'h16;
  localparam logic [7:0] MISC_CONFIG_ONE_ADDR           = 8'h17;

  localparam int AC_LSB         = 4;   // AC enables and classify enables sit in bits 7:4
  localparam int HP_ALL_BIT     = 7;
  localparam int HP_CL_LSB      = 4;
  localparam int RESTART_LSB    = 6;
  localparam int START_LSB      = 4;
  localparam int FAULT_LSB      = 2;
  localparam int REMOVAL_LSB    = 0;
  localparam int INT_EN_BIT     = 7;
  localparam int RESTART_EN_BIT = 6;
  localparam int BLOCK_POWER_ON_CLASS_FAULT_BIT    = 3;
  localparam int CL_PROT_BIT    = 2;
  localparam int OUT_ISO_BIT    = 1;

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0] TIMING_RESET   = 8'h00;
  localparam logic [7:0] MISC_RESET     = 8'hC0;
  localparam logic [7:0] MISC_WR_MASK   = 8'hCE;
  localparam logic [7:0] CLASS_OVER_LIM = 8'h07;  // class result code for current limit
  localparam logic [1:0] INIT_DONE      = 2'h3;
  localparam logic [1:0] INIT_LOAD      = 2'h2;

  // ****************************************************************
  // Timing figures and derived cycle counts
  // ****************************************************************
  localparam longint unsigned CLK_HZ        = 64'd20000000;
  localparam longint unsigned START_NOM_MS  = 64'd60;
  localparam longint unsigned FAULT_NOM_MS  = 64'd60;
  localparam longint unsigned REMOVE_NOM_MS = 64'd350;
  localparam longint unsigned BACKOFF_MS    = 64'd2200;
  localparam longint unsigned START_NOM_CYC  = START_NOM_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned FAULT_NOM_CYC  = FAULT_NOM_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned REMOVE_NOM_CYC = REMOVE_NOM_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned BACKOFF_CYC    = BACKOFF_MS * CLK_HZ / 64'd1000;

  // ****************************************************************
  // Enumerations and carriers
  // ****************************************************************
  typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_MANUAL, MODE_SEMI, MODE_AUTO} port_mode_e;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DISCOVER, SEQ_CLASSIFY} seq_e;

  typedef struct packed {
    logic       powered;
    logic       port_power_good;
    logic       discovery_done;
    logic       discovery_ok;
    logic       classify_done;
    logic       overcurrent_shutdown;
    logic [2:0] class_result;
  } port_in_s;

  typedef struct packed {
    logic       dc_monitor_run;
    logic       ac_monitor_run;
    logic       discovery_active;
    logic       classify_active;
    logic       discovery_backoff;
    logic       repower_blocked;
    logic       high_power_apply;
    logic [2:0] overcurrent_threshold_voltage;
  } port_out_s;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic port_mode_e mode_of(input logic [7:0] modes, input int p);
    mode_of = port_mode_e'(modes[2*p +: 2]);
  endfunction : mode_of

  // Scales a nominal count; removal time uses its own scale column
  function automatic logic [31:0] scale_time(input logic [1:0] code, input logic [31:0] nom,
                                             input logic removal);
    unique case (code)
      2'h0: scale_time = nom;
      2'h1: scale_time = removal ? (nom >> 2) : (nom >> 1);
      2'h2: scale_time = removal ? (nom >> 1) : (nom << 1);
      2'h3: scale_time = removal ? (nom << 1) : (nom << 2);
    endcase
  endfunction : scale_time

  // Off time after an overcurrent fault as a multiple of the fault time
  function automatic logic [31:0] restart_time(input logic [1:0] code, input logic [31:0] fault);
    unique case (code)
      2'h0: restart_time = fault << 4;
      2'h1: restart_time = fault << 5;
      2'h2: restart_time = fault << 6;
      2'h3: restart_time = 32'h0;
    endcase
  endfunction : restart_time

endpackage : pse_cfg_pkg

// *** rtl/port_timer.sv ***
// Loadable down-counter that reports busy while it is running
`timescale 1ns/10ps
module port_timer #(
  parameter int W = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } timer_state_s;

  timer_state_s state_ff;
  timer_state_s nxt_state;

  // ****************************************************************
  // Count down; a load restarts the count, a zero load stays idle
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    if (load)
      nxt_state.cnt = load_val;
    else if (state_ff.cnt != '0)
      nxt_state.cnt = state_ff.cnt - W'(1);
    nxt_state.busy = (nxt_state.cnt != '0);
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign busy = state_ff.busy;

endmodule : port_timer

// *** rtl/pse_port_config_registers.sv ***
// Per-port configuration register bank of a four-port power-sourcing controller
//
// Contract
// - Mode code 00 shutdown,01 manual,10 semi,11 auto.
// - DC enable runs DC removal monitoring.
// - AC enable runs AC removal monitoring.
// - Monitoring only while powered and power good.
// - Disconnect enables reset to 0000 plus strap.
// - Discovery before classification; classification alone allowed.
// - Manual mode enables clear when routine completes.
// - Auto entry sets enables; semi/manual clears them.
// - Discovery/classify enables reset to auto strap.
// - Backoff pauses 2.2 s after failed discovery.
// - Backoff bits reset to midspan AND auto.
// - Startup limit time scaled by code.
// - Fault limit time scaled by code.
// - Removal time scaled by code.
// - Restart off time multiple of fault time.
// - Restart protection blocks repower until timer expires.
// - Class protection lowers threshold by class result.
// - High power applied only after successful startup.
// - Isolation bit puts sense pins high impedance.
// - Bit 7 gates interrupt output, resets high.
// - Auto mode blocks power after class overcurrent.
`timescale 1ns/10ps
module pse_port_config_registers #(
  parameter logic [31:0] START_NOM_CYC  = 32'(pse_cfg_pkg::START_NOM_CYC),
  parameter logic [31:0] FAULT_NOM_CYC  = 32'(pse_cfg_pkg::FAULT_NOM_CYC),
  parameter logic [31:0] REMOVE_NOM_CYC = 32'(pse_cfg_pkg::REMOVE_NOM_CYC),
  parameter logic [31:0] BACKOFF_CYC    = 32'(pse_cfg_pkg::BACKOFF_CYC)
) (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         auto_strap,
  input  wire logic                         midspan_strap,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata,
  input  wire logic [7:0]                   port_mode,
  input  wire pse_cfg_pkg::port_in_s [3:0]  port_in,
  output pse_cfg_pkg::port_out_s [3:0]      port_out,
  input  wire logic                         int_request,
  output logic                              int_pin_out,
  output logic                              int_pin_oe,
  output logic                              sense_pin_hiz,
  output logic                              block_power_on_class_fault,
  output logic [3:0]                        power_refused,
  output logic [31:0]                       start_limit_cyc,
  output logic [31:0]                       fault_limit_cyc,
  output logic [31:0]                       removal_limit_cyc
);

  typedef struct packed {
    logic [1:0]                   strap_meta;
    logic [1:0]                   strap_sync;
    logic [1:0]                   init_cnt;
    logic [7:0]                   disconnect_monitor_enable;
    logic [7:0]                   discovery_classify_enable;
    logic [7:0]                   cadence_highpower_enable;
    logic [7:0]                   protection_timing;
    logic [7:0]                   misc_config_one;
    logic [7:0]                   mode_prev;
    pse_cfg_pkg::seq_e [3:0]      seq;
    logic [7:0]                   rdata;
    pse_cfg_pkg::port_out_s [3:0] pout;
    logic                         int_oe;
    logic                         hiz;
    logic [3:0]                   refused;
    logic [31:0]                  start_cyc;
    logic [31:0]                  fault_cyc;
    logic [31:0]                  removal_cyc;
  } cfg_state_s;

  cfg_state_s  state_ff;
  cfg_state_s  nxt_state;
  logic [3:0]  backoff_load;
  logic [3:0]  restart_load;
  logic [3:0]  backoff_busy;
  logic [3:0]  restart_busy;
  logic [31:0] restart_cyc;

  // ****************************************************************
  // Per-port backoff and restart timers
  // ****************************************************************
  assign restart_cyc = pse_cfg_pkg::restart_time(state_ff.protection_timing[pse_cfg_pkg::RESTART_LSB +: 2],
                                                 state_ff.fault_cyc);

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_port
      port_timer #(.W(32)) u_backoff (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .load     (backoff_load[gp]),
        .load_val (BACKOFF_CYC),
        .busy     (backoff_busy[gp])
      );
      port_timer #(.W(32)) u_restart (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .load     (restart_load[gp]),
        .load_val (restart_cyc),
        .busy     (restart_busy[gp])
      );
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    pse_cfg_pkg::port_mode_e m;
    pse_cfg_pkg::port_mode_e mp;
    logic                    auto_l;
    logic                    go;
    m      = pse_cfg_pkg::MODE_SHUTDOWN;
    mp     = pse_cfg_pkg::MODE_SHUTDOWN;
    auto_l = state_ff.strap_sync[0];
    go     = 1'b0;
    nxt_state = state_ff;
    backoff_load = '0;
    restart_load = '0;

    // Strap synchroniser and one-time load of strap-dependent resets
    nxt_state.strap_meta = {midspan_strap, auto_strap};
    nxt_state.strap_sync = state_ff.strap_meta;
    if (state_ff.init_cnt != pse_cfg_pkg::INIT_DONE)
      nxt_state.init_cnt = state_ff.init_cnt + 2'h1;
    if (state_ff.init_cnt == pse_cfg_pkg::INIT_LOAD)
    begin
      nxt_state.disconnect_monitor_enable = {4'h0, {4{auto_l}}};
      nxt_state.discovery_classify_enable = {8{auto_l}};
      nxt_state.cadence_highpower_enable  = {4'h0, {4{auto_l & state_ff.strap_sync[1]}}};
    end
    nxt_state.mode_prev = port_mode;

    // Per-port sequencing and status
    for (int p = 0; p < 4; p++)
    begin
      m  = pse_cfg_pkg::mode_of(port_mode, p);
      mp = pse_cfg_pkg::mode_of(state_ff.mode_prev, p);
      // A mode change to auto, semi or manual reloads this port's discovery and classify enables
      if (m != mp && state_ff.init_cnt == pse_cfg_pkg::INIT_DONE)
      begin
        if (m == pse_cfg_pkg::MODE_AUTO)
        begin
          nxt_state.discovery_classify_enable[p]   = 1'b1;
          nxt_state.discovery_classify_enable[p+4] = 1'b1;
        end
        else if (m != pse_cfg_pkg::MODE_SHUTDOWN)
        begin
          nxt_state.discovery_classify_enable[p]   = 1'b0;
          nxt_state.discovery_classify_enable[p+4] = 1'b0;
        end
      end
      go = (state_ff.init_cnt == pse_cfg_pkg::INIT_DONE) && (m != pse_cfg_pkg::MODE_SHUTDOWN)
           && !port_in[p].powered;
      unique case (state_ff.seq[p])
        pse_cfg_pkg::SEQ_IDLE:
          // A mode change first reloads the enables, so never launch from the stale value
          if (go && !backoff_busy[p] && m == mp)
          begin
            if (state_ff.discovery_classify_enable[p])
              nxt_state.seq[p] = pse_cfg_pkg::SEQ_DISCOVER;
            else if (state_ff.discovery_classify_enable[p+4])
              nxt_state.seq[p] = pse_cfg_pkg::SEQ_CLASSIFY;
          end
        pse_cfg_pkg::SEQ_DISCOVER:
          if (!go)
            nxt_state.seq[p] = pse_cfg_pkg::SEQ_IDLE;
          else if (port_in[p].discovery_done)
          begin
            if (m == pse_cfg_pkg::MODE_MANUAL)
              nxt_state.discovery_classify_enable[p] = 1'b0;
            if (!port_in[p].discovery_ok)
            begin
              backoff_load[p]  = state_ff.cadence_highpower_enable[p];
              nxt_state.seq[p] = pse_cfg_pkg::SEQ_IDLE;
            end
            else if (state_ff.discovery_classify_enable[p+4])
              nxt_state.seq[p] = pse_cfg_pkg::SEQ_CLASSIFY;
            else
              nxt_state.seq[p] = pse_cfg_pkg::SEQ_IDLE;
          end
        pse_cfg_pkg::SEQ_CLASSIFY:
          if (!go)
            nxt_state.seq[p] = pse_cfg_pkg::SEQ_IDLE;
          else if (port_in[p].classify_done)
          begin
            if (m == pse_cfg_pkg::MODE_MANUAL)
              nxt_state.discovery_classify_enable[p+4] = 1'b0;
            nxt_state.seq[p] = pse_cfg_pkg::SEQ_IDLE;
          end
        default:
          nxt_state.seq[p] = pse_cfg_pkg::SEQ_IDLE;
      endcase
      restart_load[p] = port_in[p].overcurrent_shutdown
                        && state_ff.misc_config_one[pse_cfg_pkg::RESTART_EN_BIT];

      // Per-port outputs, all registered
      nxt_state.pout[p].dc_monitor_run = state_ff.disconnect_monitor_enable[p]
                                         && port_in[p].powered && port_in[p].port_power_good;
      nxt_state.pout[p].ac_monitor_run = state_ff.disconnect_monitor_enable[p+4]
                                         && port_in[p].powered && port_in[p].port_power_good;
      nxt_state.pout[p].discovery_active  = (nxt_state.seq[p] == pse_cfg_pkg::SEQ_DISCOVER);
      nxt_state.pout[p].classify_active   = (nxt_state.seq[p] == pse_cfg_pkg::SEQ_CLASSIFY);
      nxt_state.pout[p].discovery_backoff = backoff_busy[p];
      nxt_state.pout[p].repower_blocked   = restart_busy[p];
      nxt_state.pout[p].high_power_apply  = port_in[p].port_power_good && port_in[p].powered
        && (state_ff.cadence_highpower_enable[pse_cfg_pkg::HP_ALL_BIT]
            || state_ff.cadence_highpower_enable[pse_cfg_pkg::HP_CL_LSB + p]);
      nxt_state.pout[p].overcurrent_threshold_voltage =
        state_ff.misc_config_one[pse_cfg_pkg::CL_PROT_BIT] ? port_in[p].class_result : 3'h0;
      nxt_state.refused[p] = restart_busy[p]
        || (m == pse_cfg_pkg::MODE_AUTO && state_ff.misc_config_one[pse_cfg_pkg::BLOCK_POWER_ON_CLASS_FAULT_BIT]
            && port_in[p].class_result == pse_cfg_pkg::CLASS_OVER_LIM[2:0]);
    end

    // Software write; a set from software wins over a hardware clear
    if (reg_wr && state_ff.init_cnt == pse_cfg_pkg::INIT_DONE)
    begin
      unique case (reg_addr)
        pse_cfg_pkg::DISCONNECT_MONITOR_ENABLE_ADDR: nxt_state.disconnect_monitor_enable = reg_wdata;
        pse_cfg_pkg::DISCOVERY_CLASSIFY_ENABLE_ADDR: nxt_state.discovery_classify_enable = reg_wdata;
        pse_cfg_pkg::CADENCE_HIGHPOWER_ENABLE_ADDR:  nxt_state.cadence_highpower_enable  = reg_wdata;
        pse_cfg_pkg::PROTECTION_TIMING_ADDR:         nxt_state.protection_timing         = reg_wdata;
        pse_cfg_pkg::MISC_CONFIG_ONE_ADDR:
          nxt_state.misc_config_one = reg_wdata & pse_cfg_pkg::MISC_WR_MASK;
        default: ;
      endcase
    end

    // Registered read data; unmapped offsets read zero
    if (reg_rd)
    begin
      unique case (reg_addr)
        pse_cfg_pkg::DISCONNECT_MONITOR_ENABLE_ADDR: nxt_state.rdata = state_ff.disconnect_monitor_enable;
        pse_cfg_pkg::DISCOVERY_CLASSIFY_ENABLE_ADDR: nxt_state.rdata = state_ff.discovery_classify_enable;
        pse_cfg_pkg::CADENCE_HIGHPOWER_ENABLE_ADDR:  nxt_state.rdata = state_ff.cadence_highpower_enable;
        pse_cfg_pkg::PROTECTION_TIMING_ADDR:         nxt_state.rdata = state_ff.protection_timing;
        pse_cfg_pkg::MISC_CONFIG_ONE_ADDR:           nxt_state.rdata = state_ff.misc_config_one;
        default:                                     nxt_state.rdata = 8'h00;
      endcase
    end

    // Global outputs and scaled timing counts
    nxt_state.int_oe = int_request && state_ff.misc_config_one[pse_cfg_pkg::INT_EN_BIT];
    nxt_state.hiz    = state_ff.misc_config_one[pse_cfg_pkg::OUT_ISO_BIT];
    nxt_state.start_cyc = pse_cfg_pkg::scale_time(
      state_ff.protection_timing[pse_cfg_pkg::START_LSB +: 2], START_NOM_CYC, 1'b0);
    nxt_state.fault_cyc = pse_cfg_pkg::scale_time(
      state_ff.protection_timing[pse_cfg_pkg::FAULT_LSB +: 2], FAULT_NOM_CYC, 1'b0);
    nxt_state.removal_cyc = pse_cfg_pkg::scale_time(
      state_ff.protection_timing[pse_cfg_pkg::REMOVAL_LSB +: 2], REMOVE_NOM_CYC, 1'b1);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff                   <= '0;
      state_ff.protection_timing <= pse_cfg_pkg::TIMING_RESET;
      state_ff.misc_config_one   <= pse_cfg_pkg::MISC_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  // Outputs straight from the state register; int_pin_out is tied low
  assign reg_rdata                  = state_ff.rdata;
  assign port_out                   = state_ff.pout;
  assign int_pin_out                = 1'b0;  // Open drain: only ever pulls low
  assign int_pin_oe                 = state_ff.int_oe;
  assign sense_pin_hiz              = state_ff.hiz;
  assign block_power_on_class_fault = state_ff.misc_config_one[pse_cfg_pkg::BLOCK_POWER_ON_CLASS_FAULT_BIT];
  assign power_refused              = state_ff.refused;
  assign start_limit_cyc            = state_ff.start_cyc;
  assign fault_limit_cyc            = state_ff.fault_cyc;
  assign removal_limit_cyc          = state_ff.removal_cyc;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence manual_disc_end_s;
    port_mode[1:0] == 2'h1 && state_ff.seq[0] == pse_cfg_pkg::SEQ_DISCOVER && port_in[0].discovery_done
    && !port_in[0].powered && !reg_wr;
  endsequence

  shutdown_idle_a: assert property (port_mode[1:0] == 2'h0 |=> state_ff.seq[0] == pse_cfg_pkg::SEQ_IDLE)
    else $error("port 0 sequencing while in shutdown");
  dc_monitor_a: assert property (!port_in[0].port_power_good |=> !port_out[0].dc_monitor_run)
    else $error("DC monitoring without power good");
  ac_monitor_a: assert property (state_ff.disconnect_monitor_enable[4] && port_in[0].powered
                                 && port_in[0].port_power_good |=> port_out[0].ac_monitor_run)
    else $error("AC monitoring not started");
  strap_reset_a: assert property (state_ff.init_cnt == pse_cfg_pkg::INIT_LOAD |=>
                                  state_ff.disconnect_monitor_enable == {4'h0, {4{$past(state_ff.strap_sync[0])}}})
    else $error("disconnect enable reset value wrong");
  manual_clear_a: assert property (manual_disc_end_s |=> !state_ff.discovery_classify_enable[0])
    else $error("manual discovery enable not cleared");
  auto_entry_a: assert property (port_mode[1:0] == 2'h3 && state_ff.mode_prev[1:0] != 2'h3 && !reg_wr
                                 && state_ff.init_cnt == pse_cfg_pkg::INIT_DONE
                                 |=> state_ff.discovery_classify_enable[0] && state_ff.discovery_classify_enable[4])
    else $error("auto entry did not set enables");
  backoff_hold_a: assert property (state_ff.seq[0] == pse_cfg_pkg::SEQ_DISCOVER && port_in[0].discovery_done
                                   && !port_in[0].discovery_ok && state_ff.cadence_highpower_enable[0]
                                   && port_mode[1:0] != 2'h0 && !port_in[0].powered
                                   |=> ##1 port_out[0].discovery_backoff [*2])
    else $error("backoff pause not held");
  int_gate_a: assert property (!state_ff.misc_config_one[7] |=> !int_pin_oe)
    else $error("interrupt driven while disabled");
  start_scale_a: assert property (state_ff.protection_timing[5:4] == 2'h2 |=> start_limit_cyc == (START_NOM_CYC << 1))
    else $error("startup time scaling wrong");

endmodule : pse_port_config_registers

// *** tb/port_far_end.sv ***
// Far-end port model that finishes each routine
`timescale 1ns/10ps
module port_far_end (
  input  wire logic                         sys_clk,
  input  wire logic [6:0]                   stat,
  input  wire pse_cfg_pkg::port_out_s [3:0] port_out,
  output pse_cfg_pkg::port_in_s [3:0]       port_in
);
  // One done pulse per routine, discovery passes unless stat[5] is high
  initial port_in = '0;
  always @(posedge sys_clk)
    for (int p = 0; p < 4; p++)
    begin
      port_in[p].discovery_done <= port_out[p].discovery_active & ~port_in[p].discovery_done;
      port_in[p].discovery_ok <= ~stat[5];  // Discovery fails while stat[5] is high
      port_in[p].overcurrent_shutdown <= stat[6];
      port_in[p].powered <= stat[4];
      port_in[p].port_power_good <= stat[3];
      port_in[p].class_result <= stat[2:0];
      port_in[p].classify_done <= port_out[p].classify_active & ~port_in[p].classify_done;
    end
endmodule : port_far_end

// *** tb/tb_pse_port_config_registers.sv ***
// Self-checking bench for the port configuration register bank
`timescale 1ns/10ps
module tb_pse_port_config_registers;
  logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, int_request = 0, int_pin_oe, sense_pin_hiz;
  logic [7:0] reg_addr = '0, reg_wdata = '0, port_mode = '0, reg_rdata, d;
  logic [31:0] st, ft, rt;
  logic strap_a = 0, strap_m = 0, int_out, poff;
  logic [3:0] refused;
  logic [6:0] stat = '0;
  pse_cfg_pkg::port_in_s [3:0] pin;
  pse_cfg_pkg::port_out_s [3:0] pout;
  int mismatches = 0, checks_done = 0;
  // Clock and instances
  always #25 sys_clk = ~sys_clk;
  pse_port_config_registers #(.START_NOM_CYC(40), .FAULT_NOM_CYC(40), .REMOVE_NOM_CYC(80), .BACKOFF_CYC(20)) dut_u (
    .sys_clk, .nrst, .auto_strap(strap_a), .midspan_strap(strap_m), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_mode, .port_in(pin), .port_out(pout), .int_request, .int_pin_out(int_out), .int_pin_oe,
    .sense_pin_hiz, .block_power_on_class_fault(poff), .power_refused(refused), .start_limit_cyc(st),
    .fault_limit_cyc(ft), .removal_limit_cyc(rt));
  port_far_end far_u (.sys_clk, .stat, .port_out(pout), .port_in(pin));
  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // Register write and compared read
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // Expected scaled count; removal uses its own column
  function int sc(int c, int n, bit r);
    case (c)
      0: return n;
      1: return r ? n / 4 : n / 2;
      2: return r ? n / 2 : n * 2;
      default: return r ? n * 2 : n * 4;
    endcase
  endfunction : sc
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Bounded wait on port 0 classification state
  task wait_cls(input logic v);
    int i;
    for (i = 0; i < 200 && pout[0].classify_active !== v; i++) @(negedge sys_clk);  // Look where settled
    if (i == 200)
    begin
      mismatches++;
      report_and_stop;
    end
  endtask : wait_cls
  // Main sequence
  initial
  begin
    void'($urandom(22428));
    {strap_a, strap_m} <= 2'($urandom);
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(8'h13, {4'h0, {4{strap_a}}});
    rd(8'h14, {8{strap_a}});
    rd(8'h15, {4'h0, {4{strap_a & strap_m}}});
    rd(8'h16, 8'h00);
    rd(8'h17, 8'hC0);
    for (int c = 0; c < 4; c++)
    begin
      d = {2'($urandom), 6'(c * 21)};
      wr(8'h16, d);
      repeat (2) @(posedge sys_clk);
      #1 chk(st, sc(c, 40, 0));
      chk(ft, sc(c, 40, 0));
      chk(rt, sc(c, 80, 1));
    end
    d = 8'($urandom) | 8'h80;
    wr(8'h17, d);
    wr(8'h20, 8'hFF);
    rd(8'h17, d & 8'hCE);
    chk(sense_pin_hiz, d[1]);
    @(posedge sys_clk) int_request <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(int_pin_oe, 1'b1);
    wr(8'h17, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk(int_pin_oe, 1'b0);
    @(posedge sys_clk) port_mode <= 8'h55;
    rd(8'h14, 8'h00);
    wr(8'h14, 8'h11);
    wait_cls(1'b1);
    chk(pout[0].discovery_active, 1'b0);
    chk(pout[0].dc_monitor_run, 1'b0);
    wait_cls(1'b0);
    rd(8'h14, 8'h00);
    // Failed discovery with cadence backoff enabled
    wr(8'h15, 8'h01);
    @(posedge sys_clk) stat <= 7'h20;
    wr(8'h14, 8'h01);
    repeat (8) @(posedge sys_clk);
    #1 chk(pout[0].discovery_backoff, 1'b1);
    rd(8'h14, 8'h00);
    // Powered ports with class over limit, auto then semi-automatic entry
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h4C);
    wr(8'h13, 8'h11);
    wr(8'h15, 8'h80);
    @(posedge sys_clk) stat <= 7'h1F;
    @(posedge sys_clk) port_mode <= 8'hFF;
    rd(8'h14, 8'hFF);
    chk(pout[0].dc_monitor_run, 1'b1);
    chk(pout[0].ac_monitor_run, 1'b1);
    chk(pout[0].high_power_apply, 1'b1);
    chk(pout[0].overcurrent_threshold_voltage, 3'h7);
    chk(refused, 4'hF);
    chk(poff, 1'b1);
    chk(int_out, 1'b0);
    @(posedge sys_clk) port_mode <= 8'hAA;
    rd(8'h14, 8'h00);
    chk(refused, 4'h0);
    // One overcurrent shutdown pulse starts the restart timer
    @(posedge sys_clk) stat <= 7'h5F;
    @(posedge sys_clk) stat <= 7'h1F;
    repeat (3) @(posedge sys_clk);
    #1 chk(pout[0].repower_blocked, 1'b1);
    chk(refused, 4'hF);
    report_and_stop;
  end
endmodule : tb_pse_port_config_registers
